/* msr_bank.sv */
// Schedule register bank exposed as 16-bit slave holding registers
// Behaviour
// - Every register is one addressed 16-bit word
// - Expose only while slave off; rule set fixed
// - Slave enabled locks all mapping configuration
// - Invalid write discarded; late start pushes end
// - Hour 24 into end gives 23:59:59
// - Combined mode: one hour*100+minute register
// - Above 2400 stores 23:59:59; reads 2400
// - Combined minute 60+ stores hh:59:59
// - Stored hh:59:59 reads hh60 below 23
// - Schedule state reads one while output on
// - Enable zero forces schedule state zero
// - Kind field bits 0..2, codes 1..5
// - Bit 3 reserved, bit 4 blocked, 5..13 zero
// - Bit 14 off-rule, bit 15 in effect
// - Off-rule state one when it permits activity
// - State = OR of on terms AND off terms
// - Weekday mask bit 0 Monday to 6 Sunday
// - TCP port defaults 502, configurable
// - Answer as early as possible, before timeout
`timescale 1ns/1ns
module msr_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slave_en,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_sel,
    input wire logic [1:0] cfg_rule,
    input wire logic [15:0] cfg_data,
    output logic cfg_refused,
    output logic [15:0] tcp_port,
    output logic [15:0] resp_timeout,
    output logic exposed,
    output logic comb_mode,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_exc,
    output logic [15:0] rsp_data,
    input wire logic [2:0] now_day,
    input wire logic [16:0] now_time,
    input wire logic [3:0] ext_hit,
    output logic sched_on
);
    localparam int N = msr_pkg::NRULE;

    logic expose_r;
    logic comb_r;
    logic [15:0] port_r;
    logic [15:0] tmo_r;
    logic sched_en_r;
    logic sched_on_r;
    logic [2:0] kind_r [N];
    logic off_r [N];
    logic blk_r [N];
    logic [6:0] mask_r [N];
    logic [16:0] start_r [N];
    logic [16:0] end_r [N];
    logic rsp_valid_r;
    logic rsp_exc_r;
    logic [15:0] rsp_data_r;

    // Packed time helpers
    function automatic logic [16:0] hms(input logic [4:0] h,
                                        input logic [5:0] m,
                                        input logic [5:0] s);
        hms = {h, m, s};
    endfunction

    function automatic logic [16:0] inc_sec(input logic [16:0] t);
        logic [4:0] h;
        logic [5:0] m;
        logic [5:0] s;
        h = t[16:12];
        m = t[11:6];
        s = t[5:0];
        if (s != msr_pkg::MS_LAST) begin
            s = s + 6'h01;
        end else begin
            s = 6'h00;
            if (m != msr_pkg::MS_LAST) begin
                m = m + 6'h01;
            end else begin
                m = 6'h00;
                h = h + 5'h01;
            end
        end
        inc_sec = {h, m, s};
    endfunction

    // Combined decimal value to packed time
    function automatic logic [16:0] comb_to_t(input logic [15:0] v);
        logic [15:0] q;
        logic [15:0] r;
        q = v / msr_pkg::COMB_SCALE;
        r = v % msr_pkg::COMB_SCALE;
        if (v >= msr_pkg::COMB_DAY_END) begin
            comb_to_t = msr_pkg::T_DAY_END;
        end else if (r >= 16'(msr_pkg::MIN_LIMIT)) begin
            comb_to_t = hms(q[4:0], msr_pkg::MS_LAST,
                            msr_pkg::MS_LAST);
        end else begin
            comb_to_t = hms(q[4:0], r[5:0], 6'h00);
        end
    endfunction

    // Packed time to combined decimal value
    function automatic logic [15:0] t_to_comb(input logic [16:0] t);
        logic [15:0] hh;
        logic [15:0] mm;
        hh = 16'(t[16:12]) * msr_pkg::COMB_SCALE;
        mm = 16'(t[11:6]);
        if (t == msr_pkg::T_DAY_END) begin
            t_to_comb = msr_pkg::COMB_DAY_END;
        end else if (t[11:6] == msr_pkg::MS_LAST &&
                     t[5:0] == msr_pkg::MS_LAST &&
                     t[16:12] < msr_pkg::HOUR_LAST) begin
            t_to_comb = hh + 16'(msr_pkg::MIN_LIMIT);
        end else begin
            t_to_comb = hh + mm;
        end
    endfunction

    // Address decode
    wire in_rules = req_addr >= msr_pkg::REG_RULE_BASE &&
        req_addr < msr_pkg::REG_RULE_BASE + 16'(N << 3);
    wire [15:0] roff = req_addr - msr_pkg::REG_RULE_BASE;
    wire [1:0] ri = roff[msr_pkg::RULE_STRIDE_LOG2 +: msr_pkg::RIW];
    wire [2:0] fld = roff[2:0];
    wire sep_fld = fld == msr_pkg::F_SH || fld == msr_pkg::F_SM ||
        fld == msr_pkg::F_EH || fld == msr_pkg::F_EM;
    wire comb_fld = fld == msr_pkg::F_SC || fld == msr_pkg::F_EC;
    wire fld_ok = in_rules && !(comb_r ? sep_fld : comb_fld);
    wire hit_state = req_addr == msr_pkg::REG_SCHED_STATE;
    wire hit_en = req_addr == msr_pkg::REG_SCHED_EN;
    wire mapped = expose_r && (hit_state || hit_en || fld_ok);
    wire ro_hit = hit_state || (in_rules && fld == msr_pkg::F_KIND);
    wire take = req_valid && slave_en;
    wire wr_ok = take && req_write && mapped && !ro_hit;
    wire wr_rule = wr_ok && in_rules;

    // Rule evaluation
    logic [3:0] term;
    logic [3:0] on_m;
    logic [3:0] off_m;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_eval
            wire day_ok = mask_r[g][now_day];
            wire win = now_time >= start_r[g] && now_time <= end_r[g];
            wire wk = kind_r[g] == msr_pkg::KIND_WEEKLY;
            wire hit = wk ? (day_ok && win) : ext_hit[g];
            // Off terms read one when they allow activity
            assign term[g] = off_r[g] ? (blk_r[g] || !hit)
                : (!blk_r[g] && hit);
            assign on_m[g] = !off_r[g] && term[g];
            assign off_m[g] = off_r[g] && !term[g];
        end
    endgenerate
    wire sched_nxt = sched_en_r && (|on_m) && !(|off_m);

    // New time values for a rule write
    wire [16:0] cur_s = start_r[ri];
    wire [16:0] cur_e = end_r[ri];
    wire [4:0] wd_h = req_wdata[4:0];
    wire [5:0] wd_m = req_wdata[5:0];
    wire big_h = |req_wdata[15:5];
    wire big_m = |req_wdata[15:6];
    logic [16:0] new_s;
    logic [16:0] new_e;
    logic wr_start;
    logic val_ok;
    always_comb begin
        new_s = cur_s;
        new_e = cur_e;
        wr_start = 1'b0;
        val_ok = 1'b1;
        case (fld)
            msr_pkg::F_SH: begin
                wr_start = 1'b1;
                val_ok = !big_h && wd_h < msr_pkg::HOUR_END_CODE;
                new_s = hms(wd_h, cur_s[11:6], cur_s[5:0]);
            end
            msr_pkg::F_SM: begin
                wr_start = 1'b1;
                val_ok = !big_m && wd_m < msr_pkg::MIN_LIMIT;
                new_s = hms(cur_s[16:12], wd_m, cur_s[5:0]);
            end
            msr_pkg::F_SC: begin
                wr_start = 1'b1;
                new_s = comb_to_t(req_wdata);
            end
            msr_pkg::F_EH: begin
                if (!big_h && wd_h == msr_pkg::HOUR_END_CODE) begin
                    new_e = msr_pkg::T_DAY_END;
                end else begin
                    val_ok = !big_h && wd_h < msr_pkg::HOUR_END_CODE;
                    new_e = hms(wd_h, cur_e[11:6], cur_e[5:0]);
                end
            end
            msr_pkg::F_EM: begin
                val_ok = !big_m && wd_m < msr_pkg::MIN_LIMIT;
                new_e = hms(cur_e[16:12], wd_m, cur_e[5:0]);
            end
            msr_pkg::F_EC: begin
                new_e = comb_to_t(req_wdata);
            end
            default: begin
                val_ok = 1'b1;
            end
        endcase
        // Start past end drags end to start + 1 s; no room means discard
        if (wr_start && new_s > new_e) begin
            if (new_s == msr_pkg::T_DAY_END) begin
                val_ok = 1'b0;
            end else begin
                new_e = inc_sec(new_s);
            end
        end
        if (!wr_start && new_e < new_s) begin
            val_ok = 1'b0;
        end
    end
    wire time_wr = wr_rule && fld != msr_pkg::F_KIND &&
        fld != msr_pkg::F_MASK && val_ok;
    wire mask_wr = wr_rule && fld == msr_pkg::F_MASK;

    // Read data
    logic [15:0] kind_word;
    logic [15:0] rd_val;
    always_comb begin
        kind_word = 16'h0000;
        kind_word[msr_pkg::KW_KIND_LSB +: 3] = kind_r[ri];
        kind_word[msr_pkg::KW_BLOCKED] = blk_r[ri];
        kind_word[msr_pkg::KW_OFF] = off_r[ri];
        kind_word[msr_pkg::KW_STATE] = term[ri];
        case (fld)
            msr_pkg::F_KIND: rd_val = kind_word;
            msr_pkg::F_MASK: rd_val = {9'h000, mask_r[ri]};
            msr_pkg::F_SH: rd_val = {11'h000, cur_s[16:12]};
            msr_pkg::F_SM: rd_val = {10'h000, cur_s[11:6]};
            msr_pkg::F_EH: rd_val = {11'h000, cur_e[16:12]};
            msr_pkg::F_EM: rd_val = {10'h000, cur_e[11:6]};
            msr_pkg::F_SC: rd_val = t_to_comb(cur_s);
            msr_pkg::F_EC: rd_val = t_to_comb(cur_e);
            default: rd_val = 16'h0000;
        endcase
        if (hit_state) begin
            rd_val = {15'h0000, sched_on_r};
        end else if (hit_en) begin
            rd_val = {15'h0000, sched_en_r};
        end
    end

    // Configuration port, locked while the slave runs
    wire rule_cfg = cfg_sel == msr_pkg::CFG_RULE;
    assign cfg_refused = cfg_wr && (slave_en ||
        (rule_cfg && expose_r));
    wire cfg_ok = cfg_wr && !cfg_refused;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expose_r <= 1'b0;
            comb_r <= 1'b0;
            port_r <= msr_pkg::TCP_PORT_RST;
            tmo_r <= msr_pkg::TMO_RST;
        end else if (cfg_ok) begin
            if (cfg_sel == msr_pkg::CFG_EXPOSE) begin
                expose_r <= cfg_data[0];
            end
            if (cfg_sel == msr_pkg::CFG_COMB) begin
                comb_r <= cfg_data[0];
            end
            if (cfg_sel == msr_pkg::CFG_PORT) begin
                port_r <= cfg_data;
            end
            if (cfg_sel == msr_pkg::CFG_TMO) begin
                tmo_r <= cfg_data;
            end
        end
    end

    generate
        for (g = 0; g < N; g++) begin : g_rule
            wire sel = ri == 2'(g);
            wire kcfg = cfg_ok && rule_cfg && cfg_rule == 2'(g);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    kind_r[g] <= msr_pkg::KIND_RST;
                    off_r[g] <= 1'b0;
                    blk_r[g] <= 1'b0;
                end else if (kcfg) begin
                    kind_r[g] <= cfg_data[2:0];
                    blk_r[g] <= cfg_data[msr_pkg::KW_BLOCKED];
                    off_r[g] <= cfg_data[msr_pkg::KW_OFF];
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mask_r[g] <= msr_pkg::MASK_RST;
                end else if (mask_wr && sel) begin
                    mask_r[g] <= req_wdata[6:0];
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    start_r[g] <= msr_pkg::START_RST;
                    end_r[g] <= msr_pkg::END_RST;
                end else if (time_wr && sel) begin
                    start_r[g] <= new_s;
                    end_r[g] <= new_e;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sched_en_r <= 1'b0;
            sched_on_r <= 1'b0;
        end else begin
            if (wr_ok && hit_en) begin
                sched_en_r <= req_wdata[0];
            end
            sched_on_r <= sched_nxt;
        end
    end

    // Every request taken while the slave is enabled is answered on the next edge, well within any timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_exc_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            rsp_valid_r <= take;
            rsp_exc_r <= take && (!mapped ||
                (req_write && (ro_hit || (in_rules && !val_ok))));
            rsp_data_r <= (take && !req_write && mapped) ? rd_val
                : 16'h0000;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_exc = rsp_exc_r;
    assign rsp_data = rsp_data_r;
    assign sched_on = sched_on_r;
    assign tcp_port = port_r;
    assign resp_timeout = tmo_r;
    assign exposed = expose_r;
    assign comb_mode = comb_r;
endmodule // msr_bank

/* msr_pkg.sv */
// Constants for the schedule register bank
package msr_pkg;
    localparam int NRULE = 4;
    localparam int RIW = 2;
    // Register indices (16-bit holding registers)
    localparam logic [15:0] REG_SCHED_STATE = 16'h0000;
    localparam logic [15:0] REG_SCHED_EN = 16'h0001;
    localparam logic [15:0] REG_RULE_BASE = 16'h0010;
    localparam int RULE_STRIDE_LOG2 = 3;
    // Field offsets within one rule block
    localparam logic [2:0] F_KIND = 3'h0;
    localparam logic [2:0] F_MASK = 3'h1;
    localparam logic [2:0] F_SH = 3'h2;
    localparam logic [2:0] F_SM = 3'h3;
    localparam logic [2:0] F_EH = 3'h4;
    localparam logic [2:0] F_EM = 3'h5;
    localparam logic [2:0] F_SC = 3'h6;
    localparam logic [2:0] F_EC = 3'h7;
    // Rule kind word layout
    localparam int KW_KIND_LSB = 0;
    localparam int KW_BLOCKED = 4;
    localparam int KW_OFF = 14;
    localparam int KW_STATE = 15;
    localparam logic [2:0] KIND_WEEKLY = 3'h1;
    localparam logic [2:0] KIND_MONTH = 3'h2;
    localparam logic [2:0] KIND_YEAR = 3'h3;
    localparam logic [2:0] KIND_DATE = 3'h4;
    localparam logic [2:0] KIND_INTERVAL = 3'h5;
    // Packed time {hour[16:12], minute[11:6], second[5:0]}
    localparam int T_H_LSB = 12;
    localparam int T_M_LSB = 6;
    localparam logic [4:0] HOUR_END_CODE = 5'h18;
    localparam logic [5:0] MIN_LIMIT = 6'h3C;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [5:0] MS_LAST = 6'h3B;
    localparam logic [16:0] T_DAY_END = 17'h17EFB;
    localparam logic [15:0] COMB_DAY_END = 16'h0960;
    localparam logic [15:0] COMB_SCALE = 16'h0064;
    // Configuration selectors
    localparam logic [2:0] CFG_EXPOSE = 3'h0;
    localparam logic [2:0] CFG_COMB = 3'h1;
    localparam logic [2:0] CFG_PORT = 3'h2;
    localparam logic [2:0] CFG_TMO = 3'h3;
    localparam logic [2:0] CFG_RULE = 3'h4;
    // Values after reset
    localparam logic [15:0] TCP_PORT_RST = 16'h01F6;
    localparam logic [15:0] TMO_RST = 16'h03E8;
    localparam logic [16:0] START_RST = 17'h00000;
    localparam logic [16:0] END_RST = 17'h17EFB;
    localparam logic [6:0] MASK_RST = 7'h00;
    localparam logic [2:0] KIND_RST = 3'h1;
endpackage

/* msr_bank_asserts.sv */
// Port-level assertions for the schedule register bank
`timescale 1ns/1ns
module msr_bank_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slave_en,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_sel,
    input wire logic [15:0] cfg_data,
    input wire logic cfg_refused,
    input wire logic [15:0] tcp_port,
    input wire logic exposed,
    input wire logic comb_mode,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic rsp_valid,
    input wire logic rsp_exc
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_answer_next: assert property (
        req_valid && slave_en |=> rsp_valid)
        else $error("request not answered in the next cycle");
    a_answer_caused: assert property (
        rsp_valid |-> $past(req_valid) && $past(slave_en))
        else $error("answer without a taken request");
    a_cfg_locked: assert property (
        cfg_wr && slave_en |-> cfg_refused)
        else $error("config accepted while slave enabled");
    a_rule_frozen: assert property (
        cfg_wr && exposed && cfg_sel == msr_pkg::CFG_RULE |-> cfg_refused)
        else $error("rule config accepted while exposed");
    a_port_load: assert property (
        cfg_wr && !cfg_refused && cfg_sel == msr_pkg::CFG_PORT
        |=> tcp_port == $past(cfg_data))
        else $error("port number not loaded");
    a_map_hold: assert property (
        slave_en |=> $stable(tcp_port) && $stable(exposed)
        && $stable(comb_mode))
        else $error("mapping changed while slave enabled");
    a_hidden_refused: assert property (
        req_valid && slave_en && !exposed |=> rsp_valid && rsp_exc)
        else $error("access served while not exposed");
    a_ro_refused: assert property (
        req_valid && slave_en && req_write
        && req_addr == msr_pkg::REG_SCHED_STATE |=> rsp_valid && rsp_exc)
        else $error("write to status register accepted");
endmodule // msr_bank_asserts

bind msr_bank msr_bank_asserts u_msr_bank_asserts (
    .clk(clk), .rst_n(rst_n), .slave_en(slave_en), .cfg_wr(cfg_wr),
    .cfg_sel(cfg_sel), .cfg_data(cfg_data), .cfg_refused(cfg_refused),
    .tcp_port(tcp_port), .exposed(exposed), .comb_mode(comb_mode),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .rsp_valid(rsp_valid), .rsp_exc(rsp_exc));

/* msr_master.sv */
// Register request master model facing the schedule bank
`timescale 1ns/1ns
module msr_master (
    input wire logic clk,
    output logic req_valid,
    output logic req_write,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_exc,
    input wire logic [15:0] rsp_data
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'hA5A5;
        req_wdata = 16'h5A5A;
    end

    task automatic xfer(input logic w, input logic [15:0] a,
        input logic [15:0] d, output logic exc, output logic [15:0] q);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        // Released lines show the inverse, not the last value
        req_write = ~w;
        req_addr = ~a;
        req_wdata = ~d;
        exc = 1'bx;
        q = 16'hXXXX;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (rsp_valid === 1'b1) begin
            exc = rsp_exc;
            q = rsp_data;
        end
    endtask
endmodule // msr_master

/* test_modbus_schedule_register_bank.sv */
// Self-checking bench for the schedule register bank
`timescale 1ns/1ns
module test_modbus_schedule_register_bank;
    logic clk, rst_n, slave_en, cfg_wr, cfg_refused, exposed, comb_mode;
    logic [2:0] cfg_sel, now_day;
    logic [1:0] cfg_rule;
    logic [15:0] cfg_data, tcp_port, resp_timeout, req_addr, req_wdata;
    logic req_valid, req_write, rsp_valid, rsp_exc, sched_on;
    logic [15:0] rsp_data;
    logic [16:0] now_time;
    logic [3:0] ext_hit;
    int fails, total_checks, cycles;

    msr_bank u_msr_bank (.clk(clk), .rst_n(rst_n), .slave_en(slave_en),
        .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_rule(cfg_rule),
        .cfg_data(cfg_data), .cfg_refused(cfg_refused),
        .tcp_port(tcp_port), .resp_timeout(resp_timeout),
        .exposed(exposed), .comb_mode(comb_mode), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data),
        .now_day(now_day), .now_time(now_time), .ext_hit(ext_hit),
        .sched_on(sched_on));
    msr_master u_msr_master (.clk(clk), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data));

    always #2 clk = ~clk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a,
        input logic [15:0] d, input logic ee, input logic [15:0] eq);
        logic e;
        logic [15:0] q;
        u_msr_master.xfer(w, a, d, e, q);
        chk({15'h0000, e}, {15'h0000, ee}, "answer kind");
        chk(q, eq, "answer data");
    endtask

    task automatic cfg(input logic [2:0] s, input logic [1:0] r,
        input logic [15:0] d, input logic er);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_sel = s;
        cfg_rule = r;
        cfg_data = d;
        #1;
        chk({15'h0000, cfg_refused}, {15'h0000, er}, "config refusal");
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    // Output state lands one cycle after its inputs
    task automatic on_is(input logic e);
        repeat (2) @(negedge clk);
        chk({15'h0000, sched_on}, {15'h0000, e}, "schedule output");
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        slave_en = 1'b0;
        cfg_wr = 1'b0;
        cfg_sel = 3'h0;
        cfg_rule = 2'h0;
        cfg_data = 16'h0000;
        now_day = 3'h2;
        now_time = 17'h0C000;
        ext_hit = 4'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk(tcp_port, 16'h01F6, "port reset");
        chk(resp_timeout, 16'h03E8, "timeout reset");
        chk({15'h0000, exposed}, 16'h0000, "exposed reset");
        $display("test reset done");
        slave_en = 1'b1;
        cfg(msr_pkg::CFG_PORT, 2'h0, 16'h05DE, 1'b1);
        chk(tcp_port, 16'h01F6, "port locked");
        acc(1'b0, 16'h0001, 16'h0000, 1'b1, 16'h0000);
        $display("test lock done");
        slave_en = 1'b0;
        cfg(msr_pkg::CFG_PORT, 2'h0, 16'h05DE, 1'b0);
        chk(tcp_port, 16'h05DE, "port set");
        cfg(msr_pkg::CFG_TMO, 2'h0, 16'h0064, 1'b0);
        chk(resp_timeout, 16'h0064, "timeout set");
        cfg(msr_pkg::CFG_RULE, 2'h1, 16'h4002, 1'b0);
        cfg(msr_pkg::CFG_RULE, 2'h2, 16'h0011, 1'b0);
        cfg(msr_pkg::CFG_EXPOSE, 2'h0, 16'h0001, 1'b0);
        chk({15'h0000, exposed}, 16'h0001, "exposed flag");
        cfg(msr_pkg::CFG_RULE, 2'h0, 16'h0002, 1'b1);
        slave_en = 1'b1;
        $display("test config done");
        acc(1'b0, 16'h0010, 16'h0000, 1'b0, 16'h0001);
        acc(1'b0, 16'h0018, 16'h0000, 1'b0, 16'hC002);
        acc(1'b0, 16'h0020, 16'h0000, 1'b0, 16'h0011);
        acc(1'b1, 16'h0010, 16'hFFFF, 1'b1, 16'h0000);
        acc(1'b0, 16'h0010, 16'h0000, 1'b0, 16'h0001);
        acc(1'b1, 16'h0000, 16'h0001, 1'b1, 16'h0000);
        acc(1'b0, 16'h0008, 16'h0000, 1'b1, 16'h0000);
        acc(1'b0, 16'h0016, 16'h0000, 1'b1, 16'h0000);
        $display("test kinds done");
        acc(1'b1, 16'h0011, 16'h0004, 1'b0, 16'h0000);
        acc(1'b1, 16'h0001, 16'h0001, 1'b0, 16'h0000);
        on_is(1'b1);
        acc(1'b0, 16'h0000, 16'h0000, 1'b0, 16'h0001);
        acc(1'b0, 16'h0010, 16'h0000, 1'b0, 16'h8001);
        ext_hit = 4'h2;
        on_is(1'b0);
        acc(1'b0, 16'h0018, 16'h0000, 1'b0, 16'h4002);
        acc(1'b0, 16'h0000, 16'h0000, 1'b0, 16'h0000);
        ext_hit = 4'h0;
        acc(1'b1, 16'h0011, 16'h0001, 1'b0, 16'h0000);
        on_is(1'b0);
        acc(1'b1, 16'h0011, 16'h0004, 1'b0, 16'h0000);
        acc(1'b1, 16'h0001, 16'h0000, 1'b0, 16'h0000);
        on_is(1'b0);
        $display("test status done");
        acc(1'b1, 16'h0014, 16'h0018, 1'b0, 16'h0000);
        acc(1'b0, 16'h0014, 16'h0000, 1'b0, 16'h0017);
        acc(1'b0, 16'h0015, 16'h0000, 1'b0, 16'h003B);
        acc(1'b1, 16'h0012, 16'h0019, 1'b1, 16'h0000);
        acc(1'b1, 16'h0014, 16'h000A, 1'b0, 16'h0000);
        acc(1'b1, 16'h0012, 16'h000B, 1'b0, 16'h0000);
        acc(1'b0, 16'h0014, 16'h0000, 1'b0, 16'h000B);
        acc(1'b0, 16'h0015, 16'h0000, 1'b0, 16'h0000);
        // Window now ends before the current time, so the rule is idle
        acc(1'b0, 16'h0010, 16'h0000, 1'b0, 16'h0001);
        $display("test times done");
        slave_en = 1'b0;
        cfg(msr_pkg::CFG_COMB, 2'h0, 16'h0001, 1'b0);
        chk({15'h0000, comb_mode}, 16'h0001, "combined flag");
        slave_en = 1'b1;
        acc(1'b1, 16'h0017, 16'h0587, 1'b0, 16'h0000);
        acc(1'b0, 16'h0017, 16'h0000, 1'b0, 16'h0587);
        // Window now spans the current time again
        acc(1'b0, 16'h0010, 16'h0000, 1'b0, 16'h8001);
        acc(1'b1, 16'h0017, 16'h09C4, 1'b0, 16'h0000);
        acc(1'b0, 16'h0017, 16'h0000, 1'b0, 16'h0960);
        acc(1'b1, 16'h0017, 16'h05BC, 1'b0, 16'h0000);
        acc(1'b0, 16'h0017, 16'h0000, 1'b0, 16'h05B4);
        acc(1'b1, 16'h0017, 16'h0938, 1'b0, 16'h0000);
        acc(1'b0, 16'h0017, 16'h0000, 1'b0, 16'h0960);
        acc(1'b0, 16'h0012, 16'h0000, 1'b1, 16'h0000);
        $display("test combined done");
        close_out;
    end
endmodule // test_modbus_schedule_register_bank
